// ==== design/port_pin_pkg.sv ====
package port_pin_pkg;

    // register map, word offsets on the plain register port
    localparam logic [3:0] OFS_LATCH = 4'h0;
    localparam logic [3:0] OFS_DIR = 4'h1;
    localparam logic [3:0] OFS_MODE = 4'h2;
    localparam logic [3:0] OFS_FUNC = 4'h3;
    localparam logic [3:0] OFS_READ = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h5;

    // pin count and pin positions inside each 8-bit register
    localparam int NPINS = 8;
    localparam int PIN_TMR_Q = 0;
    localparam int PIN_CLKFAIL = 1;
    localparam int PIN_TMR_P = 2;
    localparam int PIN_RX = 3;
    localparam int PIN_TX = 4;

    // which pins carry a function-select bit
    localparam logic [7:0] HAS_FUNC = 8'h07;

    // reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_FUNC = 8'h00;

    // status field positions
    localparam int STAT_CLKFAIL = 0;
    localparam int STAT_FLASH = 1;

    // per-pin control bits carried together
    typedef struct packed {
        logic latch;
        logic dir;
        logic mode;
        logic func;
    } pin_cfg_type;

endpackage : port_pin_pkg

// ==== design/port_pin_function_select.sv ====
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - mode 0, direction 0: pin driven from latch, read returns latch, func ignored.
// - mode 0, direction 1: pin released as input, read returns sampled pin level.
// - mode 1, func 0: pin driven by peripheral output; read follows direction.
// - mode 1, func 1: pin released, level routed to peripheral input on pins 0 and 2; read follows direction.
// - pins without func bit: mode 1 alone selects the single alternate function, or drives low on pins 5 to 7 that have none.
// - clock-fail pin as port output or timer output forced low on oscillator stop.
// - forced low persists through register writes, released only by reset.
// - flash mode pin works without any port control configuration.
module port_pin_function_select (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // port pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // peripherals
    input wire logic timer_q_high_out3,
    input wire logic timer_p_out0,
    input wire logic serial_tx_out,
    output logic timer_q_event_in,
    output logic timer_p_in0,
    output logic serial_rx_in,
    // clock monitor and flash mode
    input wire logic osc_stop,
    input wire logic data_port_pin5,
    output logic flash_prog_mode_input
);

    logic [7:0] latch_r;
    logic [7:0] pin_direction_bit;
    logic [7:0] alt_mode_enable_bit;
    logic [7:0] alt_function_select_bit;
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic fsync1_r;
    logic fsync2_r;
    logic osc1_r;
    logic osc2_r;
    logic clock_fail_output;
    logic [7:0] rdata_r;
    logic [7:0] alt_out;
    logic [7:0] read_val;
    logic [7:0] status_val;
    logic [7:0] rd_mux;
    logic fail_arm;
    logic fail_set;

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_r <= port_pin_pkg::RST_LATCH;
            pin_direction_bit <= port_pin_pkg::RST_DIR;
            alt_mode_enable_bit <= port_pin_pkg::RST_MODE;
            alt_function_select_bit <= port_pin_pkg::RST_FUNC;
        end else if (wr) begin
            if (addr == port_pin_pkg::OFS_LATCH) latch_r <= wdata;
            if (addr == port_pin_pkg::OFS_DIR) pin_direction_bit <= wdata;
            if (addr == port_pin_pkg::OFS_MODE) alt_mode_enable_bit <= wdata;
            if (addr == port_pin_pkg::OFS_FUNC) alt_function_select_bit <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for pins and the oscillator-stop level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            fsync1_r <= 1'b0;
            fsync2_r <= 1'b0;
            osc1_r <= 1'b0;
            osc2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            fsync1_r <= data_port_pin5;
            fsync2_r <= fsync1_r;
            osc1_r <= osc_stop;
            osc2_r <= osc1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky clock-fail override, cleared by reset alone
    assign fail_arm = !alt_mode_enable_bit[port_pin_pkg::PIN_CLKFAIL]
        ? !pin_direction_bit[port_pin_pkg::PIN_CLKFAIL]
        : !alt_function_select_bit[port_pin_pkg::PIN_CLKFAIL];
    assign fail_set = osc2_r && fail_arm;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_fail_output <= 1'b0;
        end else if (fail_set) begin
            clock_fail_output <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alternate output sources per pin
    assign alt_out = {3'h0, serial_tx_out, 1'b0, timer_p_out0, timer_q_high_out3,
        timer_q_high_out3};

    // per-pin output and enable selection
    genvar g;
    generate
        for (g = 0; g < port_pin_pkg::NPINS; g++) begin : g_pin
            port_pin_pkg::pin_cfg_type cfg;
            wire alt_in_sel;
            wire drive_alt;
            wire drive_latch;
            assign cfg = '{latch: latch_r[g], dir: pin_direction_bit[g],
                mode: alt_mode_enable_bit[g], func: alt_function_select_bit[g]};
            // pins without a func bit use mode alone
            assign alt_in_sel = port_pin_pkg::HAS_FUNC[g] ? cfg.func
                : (g == port_pin_pkg::PIN_RX);
            assign drive_alt = cfg.mode && !alt_in_sel;
            assign drive_latch = !cfg.mode && !cfg.dir;
            assign pin_oe[g] = drive_alt || drive_latch
                || (g == port_pin_pkg::PIN_CLKFAIL && clock_fail_output);
            assign pin_out[g] = (g == port_pin_pkg::PIN_CLKFAIL && clock_fail_output)
                ? 1'b0 : (drive_alt ? alt_out[g] : (drive_latch & cfg.latch));
            // port read: latch or synced pin by direction only
            assign read_val[g] = cfg.dir ? sync2_r[g] : cfg.latch;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // timer inputs routed when mode and func select them, serial receive by mode alone
    assign timer_q_event_in = alt_mode_enable_bit[port_pin_pkg::PIN_TMR_Q]
        & alt_function_select_bit[port_pin_pkg::PIN_TMR_Q]
        & sync2_r[port_pin_pkg::PIN_TMR_Q];
    assign timer_p_in0 = alt_mode_enable_bit[port_pin_pkg::PIN_TMR_P]
        & alt_function_select_bit[port_pin_pkg::PIN_TMR_P]
        & sync2_r[port_pin_pkg::PIN_TMR_P];
    assign serial_rx_in = alt_mode_enable_bit[port_pin_pkg::PIN_RX]
        ? sync2_r[port_pin_pkg::PIN_RX] : 1'b1;

    // flash mode input needs no port setup
    assign flash_prog_mode_input = fsync2_r;

    ////////////////////////////////////////////////////////////////////////
    // read decode
    assign status_val = {6'h00, fsync2_r, clock_fail_output};
    assign rd_mux = (addr == port_pin_pkg::OFS_LATCH) ? latch_r
        : (addr == port_pin_pkg::OFS_DIR) ? pin_direction_bit
        : (addr == port_pin_pkg::OFS_MODE) ? alt_mode_enable_bit
        : (addr == port_pin_pkg::OFS_FUNC) ? (alt_function_select_bit & port_pin_pkg::HAS_FUNC)
        : (addr == port_pin_pkg::OFS_READ) ? read_val
        : (addr == port_pin_pkg::OFS_STATUS) ? status_val
        : 8'h00;

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rd ? rd_mux : 8'h00;
        end
    end
    assign rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_latch_drive: assert property (@(posedge clk) disable iff (!arst_n)
        (!alt_mode_enable_bit[5] && !pin_direction_bit[5]) |-> (pin_oe[5] && pin_out[5] == latch_r[5]))
        else $error("latch not driven on output pin");
    a_input_release: assert property (@(posedge clk) disable iff (!arst_n)
        (pin_direction_bit[6] && !alt_mode_enable_bit[6]) |-> !pin_oe[6])
        else $error("input pin still driven");
    a_read_pin: assert property (@(posedge clk) disable iff (!arst_n)
        (rd && addr == port_pin_pkg::OFS_READ && pin_direction_bit[7])
        |=> rdata[7] == $past(sync2_r[7]))
        else $error("read of input pin wrong");
    a_alt_out: assert property (@(posedge clk) disable iff (!arst_n)
        (alt_mode_enable_bit[0] && !alt_function_select_bit[0]) |-> (pin_oe[0]
        && pin_out[0] == timer_q_high_out3))
        else $error("timer output not on pin");
    a_alt_in: assert property (@(posedge clk) disable iff (!arst_n)
        (alt_mode_enable_bit[2] && alt_function_select_bit[2]) |-> (!pin_oe[2]
        && timer_p_in0 == sync2_r[2]))
        else $error("timer input not routed");
    a_single_alt: assert property (@(posedge clk) disable iff (!arst_n)
        alt_mode_enable_bit[4] |-> (pin_oe[4] && pin_out[4] == serial_tx_out))
        else $error("serial output not on pin");
    a_fail_low: assert property (@(posedge clk) disable iff (!arst_n)
        fail_set |=> (pin_oe[1] && !pin_out[1]))
        else $error("clock fail pin not forced low");
    a_fail_hold: assert property (@(posedge clk) disable iff (!arst_n)
        clock_fail_output |=> clock_fail_output && !pin_out[1])
        else $error("clock fail released without reset");
    a_flash_pass: assert property (@(posedge clk) disable iff (!arst_n)
        flash_prog_mode_input == $past(data_port_pin5, 2) || $past(!arst_n, 2))
        else $error("flash mode pin not passed");

    ////////////////////////////////////////////////////////////////////////
    // clock-fail steps: synced stop seen while armed, then pin forced low
    sequence s_fail_trigger;
        osc2_r && fail_arm;
    endsequence

    sequence s_pin_forced;
        pin_oe[port_pin_pkg::PIN_CLKFAIL] && !pin_out[port_pin_pkg::PIN_CLKFAIL];
    endsequence

    a_fail_seq: assert property (@(posedge clk) disable iff (!arst_n)
        s_fail_trigger |=> s_pin_forced)
        else $error("armed oscillator stop did not force pin low");
    a_fail_cause: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(clock_fail_output) |-> $past(fail_set))
        else $error("clock fail flag set without armed stop");

    // serial receive pin: idle high unless mode routes the pin
    a_rx_idle: assert property (@(posedge clk) disable iff (!arst_n)
        !alt_mode_enable_bit[3] |-> serial_rx_in)
        else $error("serial input not idle high");
    a_rx_route: assert property (@(posedge clk) disable iff (!arst_n)
        alt_mode_enable_bit[3] |-> (serial_rx_in == sync2_r[3] && !pin_oe[3]))
        else $error("serial input not routed from pin");

    // timer q input routed from its pin, pin released
    a_q_in: assert property (@(posedge clk) disable iff (!arst_n)
        (alt_mode_enable_bit[0] && alt_function_select_bit[0])
        |-> (timer_q_event_in == sync2_r[0] && !pin_oe[0]))
        else $error("timer event input not routed");

    // func bit ignored in plain output mode
    a_func_ignored: assert property (@(posedge clk) disable iff (!arst_n)
        (!alt_mode_enable_bit[2] && !pin_direction_bit[2])
        |-> (pin_oe[2] && pin_out[2] == latch_r[2]))
        else $error("func bit disturbed plain output");

    // port read of an output pin returns the latch
    a_read_latch: assert property (@(posedge clk) disable iff (!arst_n)
        (rd && addr == port_pin_pkg::OFS_READ && !pin_direction_bit[7])
        |=> rdata[7] == $past(latch_r[7]))
        else $error("read of output pin not latch");

    // read data stands one cycle only
    a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n)
        !rd |=> rdata == 8'h00)
        else $error("read data outside read cycle");

    // pins with no alternate drive low in mode 1
    a_no_alt_low: assert property (@(posedge clk) disable iff (!arst_n)
        alt_mode_enable_bit[6] |-> (pin_oe[6] && !pin_out[6]))
        else $error("pin without alternate not driven low");

endmodule : port_pin_function_select

// ==== bench/port_far_side.sv ====
`timescale 1ns/1ps
// far side of the pads: external drivers and pull-ups
module port_far_side (
    // drive from the port
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // external drivers
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_oe,
    // resolved pad level
    output logic [7:0] pin_in
);
    // port drive wins, then the external driver, else the pull-up level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
endmodule : port_far_side

// ==== bench/port_pin_function_select_tb_top.sv ====
`timescale 1ns/1ps
module port_pin_function_select_tb_top;
    logic clk, arst_n, wr, rd, tq, tp, tx, osc_stop, fl;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, pin_in, pin_out, pin_oe, ext_val, ext_oe, d;
    logic ev, pin0, rx, flo;
    int failures = 0, comparisons = 0, cycles = 0;
    //////////////////////////////////////////////////////////////////////////
    port_pin_function_select u_port_pin_function_select (.clk(clk), .arst_n(arst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .timer_q_high_out3(tq), .timer_p_out0(tp),
        .serial_tx_out(tx), .timer_q_event_in(ev), .timer_p_in0(pin0), .serial_rx_in(rx),
        .osc_stop(osc_stop), .data_port_pin5(fl), .flash_prog_mode_input(flo));
    port_far_side u_port_far_side (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_oe(ext_oe), .pin_in(pin_in));
    // clock and hang guard
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end
    //////////////////////////////////////////////////////////////////////////
    task end_sim();
        if (failures == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task do_reset();
        arst_n <= 0;
        repeat (8) @(posedge clk);
        arst_n <= 1;
    endtask : do_reset
    task wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, v};
        @(posedge clk);
        wr <= 0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 0;
        #1 v = rdata;
    endtask : rd_reg
    task settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    //////////////////////////////////////////////////////////////////////////
    // reset values and an unmapped offset
    task t_reset();
        rd_reg(port_pin_pkg::OFS_DIR, d); chk(d, port_pin_pkg::RST_DIR);
        rd_reg(port_pin_pkg::OFS_MODE, d); chk(d, port_pin_pkg::RST_MODE);
        rd_reg(4'h9, d); chk(d, 8'h00);
        @(posedge clk);
        #1 chk(rdata, 8'h00);
        chk(pin_oe, 8'h00);
        chk({5'h00, ev, pin0, rx}, 8'h01);
    endtask : t_reset
    // plain output then plain input
    task t_gpio();
        wr_reg(port_pin_pkg::OFS_LATCH, 8'ha5);
        wr_reg(port_pin_pkg::OFS_FUNC, 8'h07);
        wr_reg(port_pin_pkg::OFS_DIR, 8'h00);
        settle(); chk(pin_oe, 8'hff); chk(pin_out, 8'ha5);
        rd_reg(port_pin_pkg::OFS_READ, d); chk(d, 8'ha5);
        @(posedge clk);
        {ext_oe, ext_val} <= 16'hff3c;
        wr_reg(port_pin_pkg::OFS_DIR, 8'hff);
        settle(); chk(pin_oe, 8'h00);
        rd_reg(port_pin_pkg::OFS_READ, d); chk(d, 8'h3c);
    endtask : t_gpio
    // alternate outputs, then alternate inputs; latch and direction left alone
    task t_alt();
        {tq, tp, tx} <= 3'b101;
        wr_reg(port_pin_pkg::OFS_FUNC, 8'h00);
        wr_reg(port_pin_pkg::OFS_MODE, 8'h1f);
        settle(); chk(pin_oe & 8'h1f, 8'h17); chk(pin_out & 8'h17, 8'h13);
        {tq, tp, tx} <= 3'b010;
        settle(); chk(pin_out & 8'h17, 8'h04);
        wr_reg(port_pin_pkg::OFS_FUNC, 8'h07);
        ext_val <= 8'h0d;
        settle(); chk(pin_oe & 8'h0f, 8'h00); chk({ev, pin0, rx}, 3'b111);
        rd_reg(port_pin_pkg::OFS_READ, d); chk(d & 8'h0f, 8'h0d);
        ext_val <= 8'h00;
        settle(); chk({ev, pin0, rx}, 3'b000);
    endtask : t_alt
    // oscillator stop forces the clock-fail pin low until reset
    task t_clkfail();
        wr_reg(port_pin_pkg::OFS_MODE, 8'h00);
        wr_reg(port_pin_pkg::OFS_LATCH, 8'h02);
        wr_reg(port_pin_pkg::OFS_DIR, 8'hfd);
        settle(); chk(pin_out & 8'h02, 8'h02);
        @(posedge clk);
        osc_stop <= 1;
        settle(); chk(pin_oe & pin_out & 8'h02, 8'h00);
        chk(pin_oe & 8'h02, 8'h02);
        @(posedge clk);
        osc_stop <= 0;
        wr_reg(port_pin_pkg::OFS_LATCH, 8'hff);
        settle(); chk(pin_out & 8'h02, 8'h00);
        rd_reg(port_pin_pkg::OFS_STATUS, d); chk(d & 8'h01, 8'h01);
        do_reset();
        settle(); chk(pin_oe, 8'h00);
    endtask : t_clkfail
    // flash mode pin works with registers at reset
    task t_flash();
        fl <= 1;
        settle(); chk({7'h00, flo}, 8'h01);
        rd_reg(port_pin_pkg::OFS_STATUS, d); chk(d & 8'h02, 8'h02);
    endtask : t_flash
    //////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {arst_n, wr, rd, tq, tp, tx, osc_stop, fl} = '0;
        {addr, wdata, ext_val, ext_oe} = '0;
        do_reset();
        t_reset();
        t_gpio();
        t_alt();
        t_clkfail();
        t_flash();
        end_sim();
    end
endmodule : port_pin_function_select_tb_top
